// ---- isc_pkg.sv ----
// Constants, field layouts and carrier types for the interrupt and standby control block.
// Assumes a single 50 MHz clock domain and a plain address/strobe register port.
package isc_pkg;

   // Register offsets on the register port.
   localparam logic [15:0] ISC_PRIO_LO_OFS  = 16'hFF20;
   localparam logic [15:0] ISC_PRIO_HI_OFS  = 16'hFF21;
   localparam logic [15:0] ISC_EN_LO_OFS    = 16'hFF22;
   localparam logic [15:0] ISC_EN_HI_OFS    = 16'hFF23;
   localparam logic [15:0] ISC_FLAG_LO_OFS  = 16'hFF24;
   localparam logic [15:0] ISC_FLAG_HI_OFS  = 16'hFF25;
   localparam logic [15:0] ISC_VDET_OFS     = 16'hFF12;
   localparam logic [15:0] ISC_STBY_OFS     = 16'hFF26;

   // Reset values.
   localparam logic [7:0]  ISC_REG_RST      = 8'h00;
   localparam logic [14:0] ISC_FLAG_RST     = 15'h0000;
   localparam logic [1:0]  ISC_PRIO_RST     = 2'h0;

   // Field positions of the detector control and standby command registers.
   localparam int ISC_VDET_PERIODIC_BIT     = 5;
   localparam int ISC_VDET_CONT_BIT         = 4;
   localparam int ISC_STBY_HALT_BIT         = 0;
   localparam int ISC_STBY_SLEEP_BIT        = 1;

   // Flag vector layout: bits 6:0 lower register, bits 14:7 upper register.
   localparam int ISC_NUM_CAUSES            = 15;
   localparam int ISC_NUM_GROUPS            = 6;
   localparam logic [14:0] ISC_GRP_CLK_TIMER  = 15'h000F;
   localparam logic [14:0] ISC_GRP_STOPWATCH  = 15'h0070;
   localparam logic [14:0] ISC_GRP_SERIAL     = 15'h0380;
   localparam logic [14:0] ISC_GRP_KEY_PORT   = 15'h0C00;
   localparam logic [14:0] ISC_GRP_KEY_PAIR   = 15'h1000;
   localparam logic [14:0] ISC_GRP_PROG_TIMER = 15'h6000;

   // Sleep wake wait: 8192 low-speed oscillator cycles at 32.768 kHz.
   localparam int     ISC_OSC_WAIT_CYCLES   = 8192;
   localparam longint ISC_LOW_OSC_HZ        = 32768;
   localparam longint ISC_CLK_HZ            = 50000000;
   localparam longint ISC_WAKE_WAIT_CLKS    = (ISC_OSC_WAIT_CYCLES * ISC_CLK_HZ + ISC_LOW_OSC_HZ - 1) / ISC_LOW_OSC_HZ;

   // Standby controller states.
   typedef enum logic [3:0]
   {
      ISC_RUN   = 4'h1,
      ISC_HALT  = 4'h2,
      ISC_SLEEP = 4'h4,
      ISC_WAKE  = 4'h8
   } isc_state_t;

   // Event inputs from the peripherals, sampled on the system clock.
   typedef struct packed
   {
      logic       prog_timer1_underflow;
      logic       prog_timer0_underflow;
      logic       serial_rx_error;
      logic       serial_rx_done;
      logic       serial_tx_done;
      logic [2:0] stopwatch_levels;
      logic [3:0] clock_timer_levels;
   } isc_events_t;

   // Request presented to the CPU core.
   typedef struct packed
   {
      logic       valid;
      logic [1:0] level;
      logic [2:0] group;
   } isc_request_t;

endpackage

// ---- isc_grp_level.sv ----
// Per-group level qualifier for the interrupt and standby control block.
// Assumes flags, enables and priority code are registered in the caller.
`timescale 1ns/100ps
`default_nettype none
module isc_grp_level
   import isc_pkg::*;
(
   input  wire logic [14:0] flags,
   input  wire logic [14:0] enables,
   input  wire logic [14:0] group_mask,
   input  wire logic [1:0]  prio_code,
   output var  logic [1:0]  level
);

   // A group is pending if any enabled flag in it is set; a code of zero never requests.
   wire logic pending = |(flags & enables & group_mask);
   assign level = pending ? prio_code : ISC_PRIO_RST;

endmodule
`default_nettype wire

// ---- isc_core.sv ----
// Interrupt cause flags, enables, group priorities and standby control.
// Assumes peripheral event levels and key inputs are synchronous to clock.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module isc_core
   import isc_pkg::*;
#(
   parameter longint WAKE_WAIT_CLKS = ISC_WAKE_WAIT_CLKS
)
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [15:0]  addr,
   input  wire logic [7:0]   wdata,
   input  wire logic         wr_stb,
   input  wire logic         rd_stb,
   output logic [7:0]        rdata,
   input  wire isc_events_t  events,
   input  wire logic [7:0]   key_input_port_low,
   input  wire logic [7:0]   key_compare_bits,
   input  wire logic         key_pair_input_a,
   input  wire logic         key_pair_input_b,
   input  wire logic         key_pair_compare_bit_a,
   input  wire logic         key_pair_compare_bit_b,
   input  wire logic         serial_async_mode,
   input  wire logic         vdet_sampling,
   input  wire logic         cpu_mask_bit0,
   input  wire logic         cpu_mask_bit1,
   output isc_request_t      irq,
   output logic              cpu_stopped,
   output logic              periph_stopped,
   output logic              wake_to_input_vector
);

   // Registered state.
   logic [14:0] flag_r;
   logic [14:0] en_r;
   logic [7:0]  prio_lo_r;
   logic [3:0]  prio_hi_r;
   logic        vdet_cont_r;
   logic        vdet_per_r;
   logic [2:0]  sw_prev_r;
   logic [3:0]  tm_prev_r;
   logic        key_lo_prev_r;
   logic        key_hi_prev_r;
   logic        key_pair_prev_r;
   logic [23:0] wait_cnt_r;
   isc_state_t  state_r;
   isc_state_t  state_nxt;

   // Read decode: one word per offset, unmapped addresses read zero.
   function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
      hit = (a == ofs);
   endfunction

   // Mismatch detection, edge qualified so a held mismatch sets the flag once.
   wire logic key_lo_mis   = |(key_input_port_low[3:0] ^ key_compare_bits[3:0]);
   wire logic key_hi_mis   = |(key_input_port_low[7:4] ^ key_compare_bits[7:4]);
   wire logic key_pair_mis = (key_pair_input_a ^ key_pair_compare_bit_a)
                           | (key_pair_input_b ^ key_pair_compare_bit_b);

   // Set events in flag vector order (upper register then lower register).
   wire logic [3:0] tm_rise = events.clock_timer_levels & ~tm_prev_r;
   wire logic [2:0] sw_fall = ~events.stopwatch_levels & sw_prev_r;
   wire logic [14:0] set_vec =
   {
      events.prog_timer1_underflow,
      events.prog_timer0_underflow,
      key_pair_mis & ~key_pair_prev_r,
      key_hi_mis & ~key_hi_prev_r,
      key_lo_mis & ~key_lo_prev_r,
      events.serial_rx_error & serial_async_mode,
      events.serial_rx_done,
      events.serial_tx_done,
      sw_fall,
      tm_rise
   };

   // Write-one-to-clear masks; a set in the same cycle wins over the clear.
   wire logic wr_flag_lo = wr_stb & hit(addr, ISC_FLAG_LO_OFS);
   wire logic wr_flag_hi = wr_stb & hit(addr, ISC_FLAG_HI_OFS);
   wire logic [14:0] clr_vec = {wr_flag_hi ? wdata : 8'h00, wr_flag_lo ? wdata[6:0] : 7'h00};
   wire logic [14:0] flag_nxt = set_vec | (flag_r & ~clr_vec);

   // Group level evaluation, one instance per group.
   logic [1:0] lvl [ISC_NUM_GROUPS];
   wire logic [14:0] grp_masks [ISC_NUM_GROUPS] =
      '{ISC_GRP_CLK_TIMER, ISC_GRP_STOPWATCH, ISC_GRP_SERIAL,
        ISC_GRP_KEY_PORT, ISC_GRP_KEY_PAIR, ISC_GRP_PROG_TIMER};
   wire logic [1:0] grp_prio [ISC_NUM_GROUPS] =
      '{prio_lo_r[1:0], prio_lo_r[3:2], prio_lo_r[5:4], prio_lo_r[7:6], prio_hi_r[1:0], prio_hi_r[3:2]};

   genvar g;
   generate
      for (g = 0; g < ISC_NUM_GROUPS; g++)
      begin : grp
         isc_grp_level u_lvl
         (
            .flags      (flag_r),
            .enables    (en_r),
            .group_mask (grp_masks[g]),
            .prio_code  (grp_prio[g]),
            .level      (lvl[g])
         );
      end
   endgenerate

   // Highest level wins; equal levels go to the higher-numbered group in fixed order.
   logic [1:0] best_lvl;
   logic [2:0] best_grp;
   always_comb
   begin
      best_lvl = 2'h0;
      best_grp = 3'h0;
      for (int i = 0; i < ISC_NUM_GROUPS; i++)
      begin
         if (lvl[i] != 2'h0 && lvl[i] >= best_lvl)
         begin
            best_lvl = lvl[i];
            best_grp = 3'(i);
         end
      end
   end

   // Request only above the CPU mask level; the mask itself stays in the core.
   wire logic [1:0] cpu_mask = {cpu_mask_bit1, cpu_mask_bit0};
   wire logic req_ok = (best_lvl > cpu_mask);
   wire logic any_key_pending = |(flag_r & en_r & (ISC_GRP_KEY_PORT | ISC_GRP_KEY_PAIR));

   // Standby command decode.
   wire logic wr_stby   = wr_stb & hit(addr, ISC_STBY_OFS);
   wire logic halt_cmd  = wr_stby & wdata[ISC_STBY_HALT_BIT];
   wire logic sleep_cmd = wr_stby & wdata[ISC_STBY_SLEEP_BIT];
   wire logic wait_done = (wait_cnt_r == 24'h000000);

   // Standby sequencing.
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ISC_RUN:
            if (sleep_cmd)
               state_nxt = ISC_SLEEP;
            else if (halt_cmd)
               state_nxt = ISC_HALT;
         ISC_HALT:
            if (req_ok)
               state_nxt = ISC_RUN;
         ISC_SLEEP:
            if (any_key_pending)
               state_nxt = ISC_WAKE;
         ISC_WAKE:
            if (wait_done)
               state_nxt = ISC_RUN;
         default:
            state_nxt = ISC_RUN;
      endcase
   end

   // Register read mux; detector busy bit reflects live sampling.
   wire logic [7:0] rd_mux =
      hit(addr, ISC_PRIO_LO_OFS) ? prio_lo_r :
      hit(addr, ISC_PRIO_HI_OFS) ? {4'h0, prio_hi_r} :
      hit(addr, ISC_EN_LO_OFS)   ? {1'b0, en_r[6:0]} :
      hit(addr, ISC_EN_HI_OFS)   ? en_r[14:7] :
      hit(addr, ISC_FLAG_LO_OFS) ? {1'b0, flag_r[6:0]} :
      hit(addr, ISC_FLAG_HI_OFS) ? flag_r[14:7] :
      hit(addr, ISC_VDET_OFS)    ? {2'b00, vdet_per_r, vdet_cont_r | vdet_sampling, 4'h0} :
      hit(addr, ISC_STBY_OFS)    ? {6'h00, state_r == ISC_SLEEP, state_r == ISC_HALT} :
                                   8'h00;

   // Cause flags and edge history.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_r          <= ISC_FLAG_RST;
         sw_prev_r       <= 3'h0;
         tm_prev_r       <= 4'h0;
         key_lo_prev_r   <= 1'b0;
         key_hi_prev_r   <= 1'b0;
         key_pair_prev_r <= 1'b0;
      end
      else
      begin
         flag_r          <= flag_nxt;
         sw_prev_r       <= events.stopwatch_levels;
         tm_prev_r       <= events.clock_timer_levels;
         key_lo_prev_r   <= key_lo_mis;
         key_hi_prev_r   <= key_hi_mis;
         key_pair_prev_r <= key_pair_mis;
      end
   end

   // Enables and priorities, written by software.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         en_r      <= ISC_FLAG_RST;
         prio_lo_r <= ISC_REG_RST;
         prio_hi_r <= 4'h0;
      end
      else if (wr_stb)
      begin
         if (hit(addr, ISC_EN_LO_OFS))
            en_r[6:0] <= wdata[6:0];
         if (hit(addr, ISC_EN_HI_OFS))
            en_r[14:7] <= wdata;
         if (hit(addr, ISC_PRIO_LO_OFS))
            prio_lo_r <= wdata;
         if (hit(addr, ISC_PRIO_HI_OFS))
            prio_hi_r <= wdata[3:0];
      end
   end

   // Detector control bits; sleep forces both to zero while sampling finishes.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vdet_cont_r <= 1'b0;
         vdet_per_r  <= 1'b0;
      end
      else if (state_r == ISC_SLEEP || sleep_cmd)
      begin
         vdet_cont_r <= 1'b0;
         vdet_per_r  <= 1'b0;
      end
      else if (wr_stb && hit(addr, ISC_VDET_OFS))
      begin
         vdet_cont_r <= wdata[ISC_VDET_CONT_BIT];
         vdet_per_r  <= wdata[ISC_VDET_PERIODIC_BIT];
      end
   end

   // State, wake counter and registered outputs.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r              <= ISC_RUN;
         wait_cnt_r           <= 24'h000000;
         rdata                <= ISC_REG_RST;
         irq                  <= '0;
         cpu_stopped          <= 1'b0;
         periph_stopped       <= 1'b0;
         wake_to_input_vector <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         wait_cnt_r <= (state_r == ISC_SLEEP) ? 24'(WAKE_WAIT_CLKS - 1)
                     : (wait_done ? wait_cnt_r : wait_cnt_r - 24'h000001);
         rdata      <= rd_stb ? rd_mux : ISC_REG_RST;
         irq        <= '{valid: req_ok, level: best_lvl, group: best_grp};
         cpu_stopped    <= (state_nxt != ISC_RUN);
         periph_stopped <= (state_nxt == ISC_SLEEP) & ~vdet_sampling;
         wake_to_input_vector <= (state_r == ISC_WAKE) & wait_done;
      end
   end

   // Checks on the behaviour above.
   property p_flag_clear;
      @(posedge clock) disable iff (!rst_n)
      (wr_flag_hi && wdata[7] && !events.prog_timer1_underflow) |=> !flag_r[14];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("Flag not cleared by write one.");

   property p_flag_hold;
      @(posedge clock) disable iff (!rst_n)
      (flag_r[0] && !wr_flag_lo) |=> flag_r[0];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("Flag dropped without clear.");

   property p_tm_edge;
      @(posedge clock) disable iff (!rst_n)
      ($rose(events.clock_timer_levels[3])) |=> flag_r[3];
   endproperty
   a_tm_edge: assert property (p_tm_edge) else $error("Timer edge did not set flag.");

   property p_sw_edge;
      @(posedge clock) disable iff (!rst_n)
      ($fell(events.stopwatch_levels[2])) |=> flag_r[6];
   endproperty
   a_sw_edge: assert property (p_sw_edge) else $error("Stopwatch edge did not set flag.");

   property p_pt_set;
      @(posedge clock) disable iff (!rst_n)
      events.prog_timer0_underflow |=> flag_r[13];
   endproperty
   a_pt_set: assert property (p_pt_set) else $error("Timer underflow flag not set.");

   property p_req_mask;
      @(posedge clock) disable iff (!rst_n)
      irq.valid |-> (irq.level > $past(cpu_mask)) && (irq.level != 2'h0);
   endproperty
   a_req_mask: assert property (p_req_mask) else $error("Request at or below mask level.");

   property p_no_en_no_req;
      @(posedge clock) disable iff (!rst_n)
      (en_r == 15'h0000) |=> !irq.valid;
   endproperty
   a_no_en_no_req: assert property (p_no_en_no_req) else $error("Request with nothing enabled.");

   property p_sleep_vdet;
      @(posedge clock) disable iff (!rst_n)
      (state_r == ISC_SLEEP) |-> ##1 (!vdet_cont_r && !vdet_per_r);
   endproperty
   a_sleep_vdet: assert property (p_sleep_vdet) else $error("Detector bits kept in sleep.");

   property p_halt_wake;
      @(posedge clock) disable iff (!rst_n)
      (state_r == ISC_HALT && req_ok) |=> (state_r == ISC_RUN);
   endproperty
   a_halt_wake: assert property (p_halt_wake) else $error("Halt not ended by request.");

   property p_en_readback;
      @(posedge clock) disable iff (!rst_n)
      (rd_stb && hit(addr, ISC_EN_HI_OFS)) |=> (rdata == $past(en_r[14:7]));
   endproperty
   a_en_readback: assert property (p_en_readback) else $error("Enable readback differs.");

   property p_key_set;
      @(posedge clock) disable iff (!rst_n)
      (key_lo_mis && !key_lo_prev_r) |=> flag_r[10];
   endproperty
   a_key_set: assert property (p_key_set) else $error("Key mismatch did not set flag.");

   property p_wake_pulse;
      @(posedge clock) disable iff (!rst_n)
      wake_to_input_vector |-> (state_r == ISC_RUN) && !cpu_stopped;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("Wake pulse without resume.");

   property p_sleep_stop;
      @(posedge clock) disable iff (!rst_n)
      (state_r == ISC_SLEEP && !vdet_sampling && !any_key_pending) |=> periph_stopped;
   endproperty
   a_sleep_stop: assert property (p_sleep_stop) else $error("Peripherals run in sleep.");

endmodule
`default_nettype wire

// ---- isc_cpu_model.sv ----
// Behavioural CPU exception model that samples the request lines of the interrupt block.
// Assumes the request is registered on clock and the bench sets the mask level.
`timescale 1ns/100ps
`default_nettype none
module isc_cpu_model
   import isc_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire isc_request_t irq,
   input  wire logic [1:0]   mask_lvl,
   input  wire logic         nmi,
   output logic              cpu_mask_bit0,
   output logic              cpu_mask_bit1,
   output logic              taken
);
   logic [1:0] fetch_r;

   // The mask flags simply follow the level that software last set.
   assign cpu_mask_bit0 = mask_lvl[0];
   assign cpu_mask_bit1 = mask_lvl[1];

   // One opcode fetch every four cycles; a request between fetches waits, and a flag left set fires again.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fetch_r <= 2'h0;
         taken   <= 1'b0;
      end
      else
      begin
         fetch_r <= fetch_r + 2'h1;
         taken   <= (fetch_r == 2'h0) && (nmi || (irq.valid && irq.level > mask_lvl));
      end
   end
endmodule
`default_nettype wire

// ---- interrupt_and_standby_control_tb_top.sv ----
// Self-checking bench for the interrupt and standby control core.
// Assumes the core's package and the CPU model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module interrupt_and_standby_control_tb_top;
   import isc_pkg::*;
   localparam longint WAKE = 20;
   logic [15:0]  addr = 16'h0000;
   logic [7:0]   wdata = 8'h00, key_input_port_low = 8'h00, key_compare_bits = 8'h00;
   logic [7:0]   rdata;
   logic         clock = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, nmi = 1'b0;
   logic         key_pair_input_a = 1'b0, serial_async_mode = 1'b1, vdet_sampling = 1'b0;
   logic         key_pair_compare_bit_b = 1'b0;
   logic [1:0]   mask_lvl = 2'h0;
   logic         cpu_mask_bit0, cpu_mask_bit1, taken, cpu_stopped, periph_stopped, wake_to_input_vector, awake;
   isc_events_t  events = '0;
   isc_request_t irq;
   int           fails = 0, n_compared = 0;

   // Clock and a running flag that the halt test can wait on.
   always #10 clock = ~clock;
   always_comb awake = !cpu_stopped;

   // Pair compare bit a and pair input b stay tied low; compare bit b drives the second pair line.
   isc_core #(.WAKE_WAIT_CLKS(WAKE)) DUT (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .events(events), .key_input_port_low(key_input_port_low),
      .key_compare_bits(key_compare_bits), .key_pair_input_a(key_pair_input_a), .key_pair_input_b(1'b0),
      .key_pair_compare_bit_a(1'b0), .key_pair_compare_bit_b(key_pair_compare_bit_b),
      .serial_async_mode(serial_async_mode),
      .vdet_sampling(vdet_sampling), .cpu_mask_bit0(cpu_mask_bit0), .cpu_mask_bit1(cpu_mask_bit1), .irq(irq),
      .cpu_stopped(cpu_stopped), .periph_stopped(periph_stopped), .wake_to_input_vector(wake_to_input_vector));
   isc_cpu_model cpu (.clock(clock), .rst_n(rst_n), .irq(irq), .mask_lvl(mask_lvl), .nmi(nmi),
      .cpu_mask_bit0(cpu_mask_bit0), .cpu_mask_bit1(cpu_mask_bit1), .taken(taken));

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // Bus cycles: one strobe cycle each, read data taken in the cycle after the strobe.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clock);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(what, {8'h00, e}, {8'h00, d});
   endtask
   // Both flag registers compared at once; bit 7 of the lower one must read zero.
   task automatic flags_chk(input string what, input logic [14:0] e);
      logic [7:0] lo, hi;
      rd(ISC_FLAG_LO_OFS, lo);
      rd(ISC_FLAG_HI_OFS, hi);
      chk(what, {e[14:7], 1'b0, e[6:0]}, {hi, lo});
   endtask
   task automatic pulse(input int i);
      @(posedge clock);
      events[i] <= 1'b1;
      @(posedge clock);
      events[i] <= 1'b0;
      tick(3);
   endtask
   // A wait that runs out of its bound ends the run at once.
   task automatic wait_for(input string what, ref logic sig, input int bound, output int n);
      for (n = 0; n < bound && sig !== 1'b1; n++)
      begin
         @(posedge clock);
         #1;
      end
      if (sig !== 1'b1)
      begin
         $display("[FAIL] %s expected 1 seen %b", what, sig);
         fails++;
         test_done();
      end
   endtask

   task automatic t_reset();
      for (int i = 0; i < 6; i++)
         rdchk("register reset value", 16'hFF20 + 16'(i), 8'h00);
      rdchk("unmapped read", 16'h1234, 8'h00);
      chk("request at reset", 16'h0000, {10'h000, irq});
      wr(ISC_EN_LO_OFS, 8'h55);
      wr(ISC_EN_HI_OFS, 8'hAA);
      rdchk("enable low readback", ISC_EN_LO_OFS, 8'h55);
      rdchk("enable high readback", ISC_EN_HI_OFS, 8'hAA);
      wr(ISC_EN_LO_OFS, 8'h00);
      wr(ISC_EN_HI_OFS, 8'h00);
      $display("test reset and enables done");
   endtask

   // Every event input lands on its own flag bit, holds, and clears by writing one.
   task automatic t_events();
      logic [14:0] e;
      for (int i = 0; i < 12; i++)
      begin
         e = (i < 10) ? (15'h0001 << i) : (15'h0001 << (i + 3));
         pulse(i);
         tick(4);
         flags_chk("event flag", e);
         wr(ISC_FLAG_LO_OFS, 8'h00);
         wr(ISC_FLAG_HI_OFS, 8'h00);
         flags_chk("flag after zero write", e);
         wr(ISC_FLAG_LO_OFS, {1'b0, e[6:0]});
         wr(ISC_FLAG_HI_OFS, e[14:7]);
         flags_chk("flag after one write", 15'h0000);
      end
      @(posedge clock);
      serial_async_mode <= 1'b0;
      pulse(9);
      flags_chk("rx error in sync mode", 15'h0000);
      @(posedge clock);
      serial_async_mode <= 1'b1;
      $display("test event flags done");
   endtask

   task automatic t_keys();
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clock);
         key_input_port_low     <= (i == 0) ? 8'h01 : ((i == 1) ? 8'h10 : 8'h00);
         key_pair_input_a       <= (i == 2);
         key_pair_compare_bit_b <= (i == 3);
         tick(3);
         flags_chk("key mismatch flag", 15'h0400 << ((i < 3) ? i : 2));
         wr(ISC_FLAG_HI_OFS, 8'h08 << ((i < 3) ? i : 2));
         flags_chk("key flag cleared while held", 15'h0000);
         @(posedge clock);
         key_input_port_low     <= 8'h00;
         key_pair_input_a       <= 1'b0;
         key_pair_compare_bit_b <= 1'b0;
      end
      $display("test key flags done");
   endtask

   // Serial group request against every priority code and mask level, then ties between groups.
   task automatic t_prio();
      int seen;
      wr(ISC_EN_HI_OFS, 8'h01);
      pulse(7);
      for (int c = 0; c < 4; c++)
         for (int m = 0; m < 4; m++)
         begin
            wr(ISC_PRIO_LO_OFS, 8'(c << 4));
            mask_lvl <= 2'(m);
            seen = 0;
            repeat (8)
            begin
               @(posedge clock);
               #1 seen = seen | taken;
            end
            chk("request valid", 16'(c > m), {15'h0000, irq.valid});
            chk("request taken", 16'(c > m), 16'(seen));
            if (c > m)
               chk("request level and group", {11'h000, 2'(c), 3'h2}, {11'h000, irq.level, irq.group});
         end
      // The watchdog request must get through even the fullest mask.
      @(posedge clock);
      mask_lvl <= 2'h3;
      nmi      <= 1'b1;
      seen = 0;
      repeat (8)
      begin
         @(posedge clock);
         #1 seen = seen | taken;
      end
      chk("watchdog request over full mask", 16'h0001, 16'(seen));
      @(posedge clock);
      nmi      <= 1'b0;
      mask_lvl <= 2'h0;
      wr(ISC_EN_HI_OFS, 8'h00);
      tick(3);
      chk("request when disabled", 16'h0000, {15'h0000, irq.valid});
      wr(ISC_EN_HI_OFS, 8'h01);
      wr(ISC_EN_LO_OFS, 8'h01);
      pulse(0);
      wr(ISC_PRIO_LO_OFS, 8'h22);
      tick(3);
      chk("equal level tie", 16'h0032, {10'h000, irq});
      wr(ISC_PRIO_LO_OFS, 8'h23);
      tick(3);
      chk("highest level wins", 16'h0038, {10'h000, irq});
      wr(ISC_EN_HI_OFS, 8'h41);
      pulse(10);
      wr(ISC_PRIO_HI_OFS, 8'h0C);
      tick(3);
      chk("prog timer wins level three tie", 16'h003D, {10'h000, irq});
      wr(ISC_FLAG_LO_OFS, 8'h01);
      wr(ISC_FLAG_HI_OFS, 8'h41);
      wr(ISC_EN_LO_OFS, 8'h00);
      $display("test priorities done");
   endtask

   task automatic t_standby();
      int n;
      logic [7:0] d;
      wr(ISC_STBY_OFS, 8'h01);
      tick(2);
      chk("halt stops cpu only", 16'h0002, {14'h0000, cpu_stopped, periph_stopped});
      pulse(7);
      wait_for("halt ends on request", awake, 10, n);
      wr(ISC_FLAG_HI_OFS, 8'h01);
      wr(ISC_EN_LO_OFS, 8'h01);
      wr(ISC_EN_HI_OFS, 8'h08);
      wr(ISC_VDET_OFS, 8'h30);
      vdet_sampling <= 1'b1;
      wr(ISC_STBY_OFS, 8'h02);
      tick(3);
      chk("sleep waits for sampling", 16'h0002, {14'h0000, cpu_stopped, periph_stopped});
      rd(ISC_VDET_OFS, d);
      chk("detector periodic bit cleared", 16'h0000, {15'h0000, d[5]});
      @(posedge clock);
      vdet_sampling <= 1'b0;
      tick(3);
      chk("sleep stops peripherals", 16'h0003, {14'h0000, cpu_stopped, periph_stopped});
      pulse(0);
      chk("timer does not wake sleep", 16'h0001, {15'h0000, cpu_stopped});
      key_input_port_low <= 8'h01;
      wait_for("wake pulse", wake_to_input_vector, 200, n);
      chk("wake wait in range", 16'h0001, 16'(n >= WAKE && n <= WAKE + 6));
      tick(2);
      chk("cpu resumes", 16'h0000, {15'h0000, cpu_stopped});
      key_input_port_low <= 8'h00;
      wr(ISC_VDET_OFS, 8'h00);
      $display("test standby done");
   endtask

   // Reset for five cycles, then every scenario in turn.
   initial
   begin
      tick(5);
      rst_n <= 1'b1;
      t_reset();
      t_events();
      t_keys();
      t_prio();
      t_standby();
      test_done();
   end
endmodule
`default_nettype wire
